// >>> src/rsi_pkg.sv
// Purpose: Constants and types shared by the reset state initializer.
// Assumes: 10 MHz clock; AXI4-Lite with 32-bit data.
// Notes: Offsets below are byte addresses of aligned words.
package rsi_pkg;
    // Reset-time core values
    localparam logic [15:0] PC_NORMAL = 16'hfffe;
    localparam logic [15:0] PC_BOOT = 16'h1ffe;
    localparam logic [15:0] SP_RESET = 16'h00ff;
    localparam logic [15:0] VECTOR_LO_ADDR = 16'hfffe;
    localparam logic [15:0] VECTOR_HI_ADDR = 16'hffff;
    localparam logic [1:0] BANK_RESET = 2'h0;
    localparam logic [7:0] PRESCALE_RESET = 8'h00;
    // Warm-up time
    localparam int WARMUP_US = 1000;
    localparam int CLK_MHZ = 10;
    localparam int WARMUP_CYCLES = WARMUP_US * CLK_MHZ;
    localparam int WU_W = 16;
    // Register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_WARMUP = 8'h08;
    localparam logic [7:0] REG_PC = 8'h0c;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int CTRL_VDET_EN = 0;
    localparam int CTRL_LOW_OSC = 1;
    localparam int CTRL_INT_EN = 2;
    localparam int CTRL_WDT_OFF = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Sequencer phases
    typedef enum logic [1:0] {
        PH_RESET,
        PH_WARMUP,
        PH_VECTOR,
        PH_RUN
    } rsi_phase_t;
endpackage

// >>> src/rsi_bus_if.sv
// Purpose: Register access path between bus slave and sequencer.
// Assumes: Single clock domain.
// Notes: One write strobe and a read mux per cycle.
`timescale 1ns/1ns
interface rsi_bus_if;
    logic wr;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [7:0] raddr;
    logic [31:0] rdata;
    logic rhit;
    logic whit;
    modport slave (output wr, output waddr, output wdata, output wstrb, output raddr,
        input rdata, input rhit, input whit);
    modport regs (input wr, input waddr, input wdata, input wstrb, input raddr,
        output rdata, output rhit, output whit);
endinterface

// >>> src/rsi_axil_slave.sv
// Purpose: AXI4-Lite slave front end for the reset state initializer.
// Assumes: One write and one read outstanding at most.
// Notes: Unmapped addresses answer SLVERR; writes to them are dropped.
`timescale 1ns/1ns
module rsi_axil_slave (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    rsi_bus_if.slave bus
);
    logic aw_ff, w_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic do_wr;

    // Address and data may arrive in either order
    assign do_wr = aw_ff && w_ff && !bvalid;
    assign bus.wr = do_wr;
    assign bus.waddr = awaddr_ff;
    assign bus.wdata = wdata_ff;
    assign bus.wstrb = wstrb_ff;
    assign bus.raddr = araddr;

    // Write channel capture
    always_ff @(posedge clock) begin
        if (!nrst) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            bvalid <= 1'b0;
            bresp <= rsi_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_ff <= 1'b1;
                awaddr_ff <= awaddr;
            end
            if (wvalid && wready) begin
                w_ff <= 1'b1;
                wdata_ff <= wdata;
                wstrb_ff <= wstrb;
            end
            if (do_wr) begin
                aw_ff <= 1'b0;
                w_ff <= 1'b0;
                bvalid <= 1'b1;
                bresp <= bus.whit ? rsi_pkg::RESP_OKAY : rsi_pkg::RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end
    assign awready = !aw_ff && !bvalid;
    assign wready = !w_ff && !bvalid;

    // Read channel, answer one cycle after the address is taken
    always_ff @(posedge clock) begin
        if (!nrst) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= rsi_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= bus.rhit ? bus.rdata : 32'h0000_0000;
            rresp <= bus.rhit ? rsi_pkg::RESP_OKAY : rsi_pkg::RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end
    assign arready = !rvalid;
endmodule

// >>> src/rsi_reset_state_initializer.sv
// Purpose: Reset-time initial state for an 8-bit CPU core and its peripherals.
// Assumes: All reset sources are synchronous inputs; nrst is active-low, the others active-high.
// Notes: Registers over AXI4-Lite; outputs registered except the AXI ready signals.
`timescale 1ns/1ns
module rsi_reset_state_initializer #(
    parameter int WARMUP_COUNT = rsi_pkg::WARMUP_CYCLES
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic por_rst,
    input wire logic ext_rst,
    input wire logic int_rst,
    input wire logic boot_mode_sel,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic core_rst_ff,
    output logic periph_rst_ff,
    output logic [15:0] program_counter_ff,
    output logic [15:0] stack_pointer_ff,
    output logic [1:0] register_bank_selector_ff,
    output logic global_interrupt_enable_ff,
    output logic per_source_interrupt_enables_ff,
    output logic interrupt_latches_clr_ff,
    output logic high_osc_en_ff,
    output logic low_osc_en_ff,
    output logic [7:0] prescaler_ff,
    output logic wdt_en_ff,
    output logic vdet_en_ff,
    output logic port_drive_en_ff,
    output logic boot_program_load_mode_ff,
    output logic vector_fetch_ff,
    output logic cpu_run_ff
);
    rsi_bus_if bus ();
    rsi_pkg::rsi_phase_t phase_ff, nxt_phase;
    logic [rsi_pkg::WU_W-1:0] warmup_ff;
    logic [31:0] ctrl_ff;
    logic any_rst, hard_rst, warm_done, running;
    localparam logic [rsi_pkg::WU_W-1:0] WU_LAST = rsi_pkg::WU_W'(WARMUP_COUNT - 1);

    // One combined reset from every source
    assign any_rst = !nrst || por_rst || ext_rst || int_rst;
    assign hard_rst = !nrst || por_rst || ext_rst;
    assign warm_done = (warmup_ff == WU_LAST);
    assign running = (phase_ff == rsi_pkg::PH_RUN);

    rsi_axil_slave u_slave (
        .clock(clock),
        .nrst(nrst),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .bus(bus.slave)
    );

    // Phase sequencing: reset, warm-up, vector fetch, run
    always_comb begin
        nxt_phase = phase_ff;
        unique case (phase_ff)
            rsi_pkg::PH_RESET: nxt_phase = rsi_pkg::PH_WARMUP;
            rsi_pkg::PH_WARMUP: begin
                if (warm_done) begin
                    nxt_phase = rsi_pkg::PH_VECTOR;
                end
            end
            rsi_pkg::PH_VECTOR: nxt_phase = rsi_pkg::PH_RUN;
            rsi_pkg::PH_RUN: nxt_phase = rsi_pkg::PH_RUN;
        endcase
    end

    always_ff @(posedge clock) begin
        if (any_rst) begin
            phase_ff <= rsi_pkg::PH_RESET;
        end else begin
            phase_ff <= nxt_phase;
        end
    end

    // Warm-up counter on the high-frequency clock
    always_ff @(posedge clock) begin
        if (any_rst) begin
            warmup_ff <= '0;
        end else if (phase_ff == rsi_pkg::PH_WARMUP && !warm_done) begin
            warmup_ff <= warmup_ff + 1'b1;
        end
    end

    // Boot mode strap, caught while reset is active
    always_ff @(posedge clock) begin
        if (any_rst) begin
            boot_program_load_mode_ff <= boot_mode_sel;
        end
    end

    // Core state: held at reset values until the CPU runs
    always_ff @(posedge clock) begin
        // Strap read from the pin while in reset, so PC and mode flag never disagree
        if (any_rst || !running) begin
            program_counter_ff <= (any_rst ? boot_mode_sel : boot_program_load_mode_ff)
                ? rsi_pkg::PC_BOOT : rsi_pkg::PC_NORMAL;
            stack_pointer_ff <= rsi_pkg::SP_RESET;
            register_bank_selector_ff <= rsi_pkg::BANK_RESET;
        end
        // RAM, working registers and flags are not touched here
    end

    // Vector fetch strobe and run flag
    always_ff @(posedge clock) begin
        if (any_rst) begin
            vector_fetch_ff <= 1'b0;
            cpu_run_ff <= 1'b0;
            core_rst_ff <= 1'b1;
            periph_rst_ff <= 1'b1;
        end else begin
            vector_fetch_ff <= (phase_ff == rsi_pkg::PH_WARMUP) && warm_done;
            cpu_run_ff <= (phase_ff == rsi_pkg::PH_VECTOR) || running;
            core_rst_ff <= !(phase_ff == rsi_pkg::PH_VECTOR || running);
            periph_rst_ff <= (phase_ff == rsi_pkg::PH_RESET);
        end
    end

    // Control register, cleared by any reset; an internal reset alone keeps the voltage-detect bit
    always_ff @(posedge clock) begin
        if (hard_rst) begin
            ctrl_ff <= rsi_pkg::CTRL_RESET;
        end else if (any_rst) begin
            ctrl_ff <= rsi_pkg::CTRL_RESET | (ctrl_ff & (32'h1 << rsi_pkg::CTRL_VDET_EN));
        end else if (bus.wr && bus.waddr == rsi_pkg::REG_CTRL && running) begin
            for (int i = 0; i < 4; i++) begin
                if (bus.wstrb[i]) begin
                    ctrl_ff[i*8 +: 8] <= bus.wdata[i*8 +: 8];
                end
            end
        end
    end

    // Clock, interrupt and watchdog outputs gated by phase
    always_ff @(posedge clock) begin
        if (any_rst || !running) begin
            high_osc_en_ff <= 1'b1;
            low_osc_en_ff <= 1'b0;
            global_interrupt_enable_ff <= 1'b0;
            per_source_interrupt_enables_ff <= 1'b0;
            interrupt_latches_clr_ff <= 1'b1;
            prescaler_ff <= rsi_pkg::PRESCALE_RESET;
            wdt_en_ff <= 1'b0;
            port_drive_en_ff <= 1'b0;
        end else begin
            high_osc_en_ff <= 1'b1;
            low_osc_en_ff <= ctrl_ff[rsi_pkg::CTRL_LOW_OSC];
            global_interrupt_enable_ff <= ctrl_ff[rsi_pkg::CTRL_INT_EN];
            per_source_interrupt_enables_ff <= ctrl_ff[rsi_pkg::CTRL_INT_EN];
            interrupt_latches_clr_ff <= 1'b0;
            prescaler_ff <= prescaler_ff + 8'h01;
            wdt_en_ff <= !ctrl_ff[rsi_pkg::CTRL_WDT_OFF];
            port_drive_en_ff <= 1'b1;
        end
    end

    // Voltage detection enable follows its control bit
    always_ff @(posedge clock) begin
        if (hard_rst) begin
            vdet_en_ff <= 1'b0;
        end else begin
            vdet_en_ff <= ctrl_ff[rsi_pkg::CTRL_VDET_EN];
        end
    end

    // Register decode used by both read and write paths
    function automatic logic reg_hit(input logic [7:0] a, input logic wr);
        reg_hit = (a == rsi_pkg::REG_CTRL) ||
            (!wr && (a == rsi_pkg::REG_STATUS || a == rsi_pkg::REG_WARMUP
            || a == rsi_pkg::REG_PC));
    endfunction

    assign bus.whit = reg_hit(bus.waddr, 1'b1);
    assign bus.rhit = reg_hit(bus.raddr, 1'b0);

    // Read mux
    always_comb begin
        bus.rdata = 32'h0000_0000;
        unique case (bus.raddr)
            rsi_pkg::REG_CTRL: bus.rdata = ctrl_ff;
            rsi_pkg::REG_STATUS: bus.rdata = {26'h0, boot_program_load_mode_ff, wdt_en_ff,
                vdet_en_ff, cpu_run_ff, 2'(phase_ff)};
            rsi_pkg::REG_WARMUP: bus.rdata = 32'(warmup_ff);
            rsi_pkg::REG_PC: bus.rdata = {stack_pointer_ff, program_counter_ff};
            default: bus.rdata = 32'h0000_0000;
        endcase
    end
endmodule

// >>> tb/rsi_checker.sv
// Purpose: Port assertions for the reset state initializer.
// Assumes: Bench runs WARMUP_COUNT at 8, the held-run length below.
// Notes: Bound into the design top after the module.
`timescale 1ns/1ns
module rsi_checker #(
    parameter int WARMUP_COUNT = 8
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic por_rst,
    input wire logic ext_rst,
    input wire logic int_rst,
    input wire logic boot_mode_sel,
    input wire logic core_rst_ff,
    input wire logic [15:0] program_counter_ff,
    input wire logic [15:0] stack_pointer_ff,
    input wire logic [1:0] register_bank_selector_ff,
    input wire logic global_interrupt_enable_ff,
    input wire logic per_source_interrupt_enables_ff,
    input wire logic interrupt_latches_clr_ff,
    input wire logic high_osc_en_ff,
    input wire logic low_osc_en_ff,
    input wire logic [7:0] prescaler_ff,
    input wire logic wdt_en_ff,
    input wire logic vdet_en_ff,
    input wire logic port_drive_en_ff,
    input wire logic boot_program_load_mode_ff,
    input wire logic vector_fetch_ff,
    input wire logic cpu_run_ff
);
    logic any_rst;
    int wu_cnt_ff = 0;
    // Any source counts, so the cycle count restarts on each of them
    assign any_rst = !nrst || por_rst || ext_rst || int_rst;
    always_ff @(posedge clock) begin
        if (any_rst) begin
            wu_cnt_ff <= 0;
        end else if (core_rst_ff) begin
            wu_cnt_ff <= wu_cnt_ff + 1;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence s_release;
        any_rst ##1 !any_rst;
    endsequence
    sequence s_held;
        core_rst_ff [*8];
    endsequence
    a_pc_sp_hold: assert property (core_rst_ff |-> stack_pointer_ff == rsi_pkg::SP_RESET &&
        program_counter_ff == (boot_program_load_mode_ff ? rsi_pkg::PC_BOOT : rsi_pkg::PC_NORMAL))
        else $error("pc or sp wrong while held");
    a_bank_zero: assert property (core_rst_ff |-> register_bank_selector_ff == 2'h0)
        else $error("bank not zero while held");
    a_ints_off: assert property (core_rst_ff |-> !global_interrupt_enable_ff &&
        !per_source_interrupt_enables_ff && interrupt_latches_clr_ff)
        else $error("interrupts not off while held");
    a_osc_state: assert property (high_osc_en_ff && (!core_rst_ff || !low_osc_en_ff))
        else $error("oscillator state wrong");
    a_quiet_held: assert property (core_rst_ff |-> prescaler_ff == 8'h00 &&
        !wdt_en_ff && !port_drive_en_ff) else $error("prescaler, wdt or ports active");
    a_wdt_enable: assert property ($rose(cpu_run_ff) |-> ##[0:1] wdt_en_ff)
        else $error("watchdog not enabled at run");
    a_warmup_hold: assert property (s_release |-> s_held)
        else $error("warm-up cut short");
    a_warmup_len: assert property ($fell(core_rst_ff) |-> wu_cnt_ff >= WARMUP_COUNT &&
        wu_cnt_ff <= WARMUP_COUNT + 6) else $error("warm-up length wrong");
    a_vec_pulse: assert property (vector_fetch_ff && !any_rst |=>
        !vector_fetch_ff && cpu_run_ff) else $error("vector pulse wrong");
    a_vdet_clear: assert property (por_rst || ext_rst |=> !vdet_en_ff)
        else $error("vdet not cleared");
    a_vdet_keep: assert property (int_rst && !por_rst && !ext_rst |=> $stable(vdet_en_ff))
        else $error("vdet changed on internal reset");
    a_mode_take: assert property (any_rst |=>
        boot_program_load_mode_ff == $past(boot_mode_sel)) else $error("mode not captured");
endmodule
bind rsi_reset_state_initializer rsi_checker #(.WARMUP_COUNT(WARMUP_COUNT)) i_rsi_checker (
    .clock, .nrst, .por_rst, .ext_rst, .int_rst, .boot_mode_sel, .core_rst_ff,
    .program_counter_ff, .stack_pointer_ff, .register_bank_selector_ff,
    .global_interrupt_enable_ff, .per_source_interrupt_enables_ff, .interrupt_latches_clr_ff,
    .high_osc_en_ff, .low_osc_en_ff, .prescaler_ff, .wdt_en_ff, .vdet_en_ff,
    .port_drive_en_ff, .boot_program_load_mode_ff, .vector_fetch_ff, .cpu_run_ff);

// >>> tb/rsi_core_model.sv
// Purpose: Behavioural CPU core on the far side of the reset block.
// Assumes: The core fetches its vector only on the warm-up end pulse.
// Notes: Keeps no flags or RAM, as reset leaves them undefined.
`timescale 1ns/1ns
module rsi_core_model (
    input wire logic clock,
    input wire logic core_rst_ff,
    input wire logic vector_fetch_ff,
    input wire logic [15:0] program_counter_ff,
    output logic [15:0] fetch_pc,
    output int fetch_count
);
    logic [15:0] held_pc = 16'h0000;
    initial fetch_pc = 16'h0000;
    initial fetch_count = 0;
    // Idle while held; the pulse is the only start, so a double pulse shows
    always @(posedge clock) begin
        if (core_rst_ff) begin
            held_pc <= program_counter_ff;
        end
        if (vector_fetch_ff) begin
            fetch_pc <= held_pc;
            fetch_count <= fetch_count + 1;
        end
    end
endmodule

// >>> tb/tb_top.sv
// Purpose: Self-checking bench for the reset state initializer.
// Assumes: Warm-up shortened to 8 cycles.
// Notes: Bus handshakes are sampled at the falling edge.
`timescale 1ns/1ns
module tb_top;
    localparam int WU = 8;
    logic clock = 0, nrst = 0, por_rst = 0, ext_rst = 0, int_rst = 0, boot_mode_sel = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, core_rst_ff, periph_rst_ff;
    logic [1:0] bresp, rresp, register_bank_selector_ff, rsp;
    logic [15:0] program_counter_ff, stack_pointer_ff, fetch_pc;
    logic [7:0] prescaler_ff;
    logic global_interrupt_enable_ff, per_source_interrupt_enables_ff, interrupt_latches_clr_ff;
    logic high_osc_en_ff, low_osc_en_ff, wdt_en_ff, vdet_en_ff, port_drive_en_ff;
    logic boot_program_load_mode_ff, vector_fetch_ff, cpu_run_ff;
    int fetch_count, n, failures = 0, check_count = 0;
    always #50 clock = ~clock;
    rsi_reset_state_initializer #(.WARMUP_COUNT(WU)) i_rsi_reset_state_initializer (.clock,
        .nrst, .por_rst, .ext_rst, .int_rst, .boot_mode_sel, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .core_rst_ff, .periph_rst_ff,
        .program_counter_ff, .stack_pointer_ff, .register_bank_selector_ff,
        .global_interrupt_enable_ff, .per_source_interrupt_enables_ff,
        .interrupt_latches_clr_ff, .high_osc_en_ff, .low_osc_en_ff, .prescaler_ff, .wdt_en_ff,
        .vdet_en_ff, .port_drive_en_ff, .boot_program_load_mode_ff, .vector_fetch_ff,
        .cpu_run_ff);
    rsi_core_model i_rsi_core_model (.clock, .core_rst_ff, .vector_fetch_ff,
        .program_counter_ff, .fetch_pc, .fetch_count);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("failures %0d checks %0d", failures, check_count);
        if (failures == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Write holds each channel until its own handshake, then waits for B
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok, w_ok, b_ok;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(negedge clock);
            aw_ok = awvalid && awready;
            w_ok = wvalid && wready;
            b_ok = bvalid;
            rsp = bresp;
            @(posedge clock);
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
            if (b_ok) break;
        end
        bready <= 1'b0;
        @(posedge clock);
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d);
        logic ar_ok, r_ok;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(negedge clock);
            ar_ok = arvalid && arready;
            r_ok = rvalid;
            d = rdata;
            rsp = rresp;
            @(posedge clock);
            if (ar_ok) arvalid <= 1'b0;
            if (r_ok) break;
        end
        rready <= 1'b0;
        @(posedge clock);
    endtask
    // Held state is the same in reset and in warm-up
    task automatic chk_held(input logic boot);
        chk(program_counter_ff, boot ? rsi_pkg::PC_BOOT : rsi_pkg::PC_NORMAL);
        chk(stack_pointer_ff, rsi_pkg::SP_RESET);
        chk(register_bank_selector_ff, 2'h0);
        chk({global_interrupt_enable_ff, per_source_interrupt_enables_ff,
            interrupt_latches_clr_ff}, 3'h1);
        chk({high_osc_en_ff, low_osc_en_ff}, 2'h2);
        chk({prescaler_ff, wdt_en_ff, port_drive_en_ff, cpu_run_ff}, 11'h0);
    endtask
    // Src bits are nrst-low, por, ext, int; leaves cycles from release to run in n
    task automatic rst_cycle(input logic [3:0] src, input logic boot);
        int f0;
        f0 = fetch_count;
        boot_mode_sel <= boot;
        {nrst, por_rst, ext_rst, int_rst} <= src ^ 4'h8;
        repeat (3) @(posedge clock);
        @(negedge clock);
        chk_held(boot);
        chk(periph_rst_ff, 1'b1);
        @(posedge clock);
        {nrst, por_rst, ext_rst, int_rst} <= 4'h8;
        n = 0;
        do begin
            @(negedge clock);
            n++;
            if (n == 4) chk_held(boot);
        end while (!cpu_run_ff && n < 100);
        @(posedge clock);
        chk(n >= WU + 1 && n <= WU + 6, 1'b1);
        chk(fetch_count - f0, 32'h1);
        chk(fetch_pc, boot ? rsi_pkg::PC_BOOT : rsi_pkg::PC_NORMAL);
        // Run-time outputs launch on this edge, so look after it settles
        @(negedge clock);
        chk(wdt_en_ff, 1'b1);
        chk(port_drive_en_ff, 1'b1);
        chk(periph_rst_ff, 1'b0);
        @(posedge clock);
    endtask
    task automatic t_power_on();
        rst_cycle(4'hc, 1'b0);
        chk(vdet_en_ff, 1'b0);
    endtask
    // Second internal reset in mid warm-up must restart the whole count
    task automatic t_restart();
        axw(rsi_pkg::REG_CTRL, 32'h1);
        int_rst <= 1'b1;
        repeat (2) @(posedge clock);
        int_rst <= 1'b0;
        repeat (4) @(posedge clock);
        rst_cycle(4'h1, 1'b0);
        chk(vdet_en_ff, 1'b1);
    endtask
    task automatic t_regs();
        logic [31:0] d;
        axr(8'h10, d);
        chk(rsp, rsi_pkg::RESP_SLVERR);
        chk(d, 32'h0);
        axw(rsi_pkg::REG_STATUS, 32'h0);
        chk(rsp, rsi_pkg::RESP_SLVERR);
        axw(rsi_pkg::REG_CTRL, 32'h7);
        chk(rsp, rsi_pkg::RESP_OKAY);
        axr(rsi_pkg::REG_CTRL, d);
        chk(d, 32'h7);
        axr(rsi_pkg::REG_PC, d);
        chk(d, {rsi_pkg::SP_RESET, rsi_pkg::PC_NORMAL});
        axr(rsi_pkg::REG_WARMUP, d);
        chk(d, 32'(WU - 1));
        chk({low_osc_en_ff, global_interrupt_enable_ff, wdt_en_ff}, 3'h7);
    endtask
    task automatic t_boot();
        logic [31:0] d;
        rst_cycle(4'h4, 1'b1);
        chk(vdet_en_ff, 1'b0);
        axr(rsi_pkg::REG_STATUS, d);
        chk(d, 32'h37);
        rst_cycle(4'h8, 1'b0);
    endtask
    initial begin
        t_power_on();
        t_restart();
        t_regs();
        t_boot();
        end_sim();
    end
    // Whole run is well under 600 cycles
    initial begin
        #(3000 * 100);
        failures++;
        end_sim();
    end
endmodule
